//--- radio_mode_pkg.sv
package radio_mode_pkg;
  localparam int CLK_MHZ        = 40;
  localparam int HOLD_MIN_US    = 10;
  localparam int CARRIER_MIN_US = 128;
  localparam int SETTLE_MAX_US  = 130;
  localparam int HOLD_CYC       = HOLD_MIN_US * CLK_MHZ;
  localparam int CARRIER_CYC    = CARRIER_MIN_US * CLK_MHZ;
  localparam int SETTLE_CYC     = SETTLE_MAX_US * CLK_MHZ;
  localparam int CNT_W          = 13;
  localparam logic [11:0] BASE_FREQ_MHZ = 12'h0960;
  localparam int CHAN_W         = 7;

  typedef enum logic [2:0] {
    POWER_DOWN, STANDBY_1, STANDBY_2, RX_SETTLE, RX_ACTIVE, TX_SETTLE, TX_ACTIVE
  } mode_type;

  typedef struct packed {
    logic              powerUp;
    logic              primaryRx;
    logic              airRate2m;
    logic [1:0]        txPowerLevel;
    logic [CHAN_W-1:0] channelNumber;
  } config_type;

  typedef struct packed {
    logic [11:0] freqMhz;
    logic        rate2m;
    logic [1:0]  powerCode;
    logic        txOn;
    logic        rxOn;
    logic        synthOn;
  } radio_type;
endpackage : radio_mode_pkg

//--- radio_mode_control.sv
`timescale 1ns/1ps
module radio_mode_control (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Host configuration and activate pin
  input  wire radio_mode_pkg::config_type cfg,
  input  wire logic                     activatePin,
  // FIFO and protocol engine status
  input  wire logic                     txFifoEmpty,
  input  wire logic                     txLoadDone,
  input  wire logic                     packetDone,
  input  wire logic                     autoEngineHold,
  input  wire logic                     rxPacketValid,
  input  wire logic                     addrMatch,
  input  wire logic                     crcOk,
  input  wire logic                     rxFifoFull,
  input  wire logic                     rfSignalPresent,
  // Outputs
  output radio_mode_pkg::mode_type      mode,
  output radio_mode_pkg::radio_type     radio,
  output logic                          rxFifoWrite,
  output logic                          rxPacketDropped,
  output logic                          txFifoPop,
  output logic                          carrierDetectFlag,
  output logic                          hostAccessOk
);
  import radio_mode_pkg::*;

  // Two-flop synchronisers for outside levels
  logic [1:0] pinSync_q, sigSync_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pinSync_q <= 2'h0;
      sigSync_q <= 2'h0;
    end else begin
      pinSync_q <= {pinSync_q[0], activatePin};
      sigSync_q <= {sigSync_q[0], rfSignalPresent};
    end
  end
  wire activeHigh = pinSync_q[1];
  wire rfSeen     = sigSync_q[1];

  mode_type mode_q, mode_d;
  logic [CNT_W-1:0] holdCnt_q, settleCnt_q, cdCnt_q;
  logic pulseArmed_q, oneShot_q, carrier_q;

  // Activate-high time, armed once it passes the minimum
  wire holdMet = (holdCnt_q >= CNT_W'(HOLD_CYC));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) holdCnt_q <= '0;
    else if (!activeHigh) holdCnt_q <= '0;
    else if (!holdMet) holdCnt_q <= holdCnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) pulseArmed_q <= 1'b0;
    else if (mode_q != STANDBY_1) pulseArmed_q <= 1'b0;
    else if (holdMet) pulseArmed_q <= 1'b1;
  end

  wire settleDone = (settleCnt_q == CNT_W'(SETTLE_CYC - 1));
  wire isSettle   = (mode_q == RX_SETTLE) || (mode_q == TX_SETTLE);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) settleCnt_q <= '0;
    else if (isSettle && (mode_d == mode_q)) settleCnt_q <= settleCnt_q + 1'b1;
    else settleCnt_q <= '0;
  end

  wire wantRx   = cfg.powerUp && cfg.primaryRx && activeHigh;
  wire txReady  = cfg.powerUp && !cfg.primaryRx && !txFifoEmpty;
  wire finishTx = (mode_q == TX_ACTIVE) && packetDone;

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      POWER_DOWN: if (cfg.powerUp) mode_d = STANDBY_1;
      STANDBY_1: begin
        if (wantRx) mode_d = RX_SETTLE;
        else if (txReady && (pulseArmed_q || holdMet)) mode_d = TX_SETTLE;
        else if (cfg.powerUp && !cfg.primaryRx && activeHigh && txFifoEmpty)
          mode_d = STANDBY_2;
      end
      STANDBY_2: begin
        if (!activeHigh || cfg.primaryRx) mode_d = STANDBY_1;
        else if (txLoadDone || !txFifoEmpty) mode_d = TX_SETTLE;
      end
      RX_SETTLE: if (settleDone) mode_d = RX_ACTIVE;
      RX_ACTIVE: begin
        if (!activeHigh && !autoEngineHold) mode_d = STANDBY_1;
        else if (!cfg.primaryRx && !autoEngineHold) mode_d = TX_SETTLE;
      end
      TX_SETTLE: if (settleDone) mode_d = TX_ACTIVE;
      TX_ACTIVE: begin
        if (finishTx) begin
          if (!activeHigh || oneShot_q) mode_d = STANDBY_1;
          else if (!txFifoEmpty) mode_d = TX_ACTIVE;
          else mode_d = STANDBY_2;
        end
      end
      default: mode_d = STANDBY_1;
    endcase
    if ((mode_q == TX_SETTLE || mode_q == RX_SETTLE) && !activeHigh) mode_d = STANDBY_1;
    if (cfg.powerUp && mode_q == POWER_DOWN) mode_d = STANDBY_1;
    if (!cfg.powerUp) mode_d = POWER_DOWN;
  end

  // Pulse shorter than packet marks a one-shot send; held pin keeps draining
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) oneShot_q <= 1'b0;
    else if (mode_q == STANDBY_1) oneShot_q <= 1'b0;
    else if (mode_q == TX_ACTIVE && !activeHigh) oneShot_q <= 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) mode_q <= POWER_DOWN;
    else mode_q <= mode_d;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cdCnt_q   <= '0;
      carrier_q <= 1'b0;
    end else if (mode_q != RX_ACTIVE || !rfSeen) begin
      cdCnt_q   <= '0;
      carrier_q <= 1'b0;
    end else if (cdCnt_q < CNT_W'(CARRIER_CYC - 1)) begin
      cdCnt_q   <= cdCnt_q + 1'b1;
    end else begin
      carrier_q <= 1'b1;
    end
  end

  wire goodPacket = (mode_q == RX_ACTIVE) && rxPacketValid && addrMatch && crcOk;
  assign rxFifoWrite     = goodPacket && !rxFifoFull;
  assign rxPacketDropped = goodPacket && rxFifoFull;
  assign txFifoPop       = finishTx;
  assign hostAccessOk    = 1'b1;

  radio_type radio_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) radio_q <= '0;
    else begin
      radio_q.freqMhz   <= BASE_FREQ_MHZ + {5'h00, cfg.channelNumber};
      radio_q.rate2m    <= cfg.airRate2m;
      radio_q.powerCode <= cfg.txPowerLevel;
      radio_q.txOn      <= (mode_d == TX_ACTIVE);
      radio_q.rxOn      <= (mode_d == RX_ACTIVE);
      radio_q.synthOn   <= (mode_d == TX_SETTLE) || (mode_d == RX_SETTLE)
                           || (mode_d == TX_ACTIVE) || (mode_d == RX_ACTIVE);
    end
  end
  assign radio             = radio_q;
  assign mode              = mode_q;
  assign carrierDetectFlag = carrier_q;

  property p_pwrdown;
    @(posedge clk) disable iff (!resetn) !cfg.powerUp |=> mode_q == POWER_DOWN;
  endproperty
  a_pwrdown: assert property (p_pwrdown) else $error("not in power down");
  property p_stby1;
    @(posedge clk) disable iff (!resetn)
      (mode_q == POWER_DOWN && cfg.powerUp) |=> mode_q == STANDBY_1;
  endproperty
  a_stby1: assert property (p_stby1) else $error("no standby-I");
  property p_fall;
    @(posedge clk) disable iff (!resetn)
      (mode_q == RX_ACTIVE && !activeHigh && !autoEngineHold && cfg.powerUp)
      |=> mode_q == STANDBY_1;
  endproperty
  a_fall: assert property (p_fall) else $error("no fallback");
  property p_rxentry;
    @(posedge clk) disable iff (!resetn)
      (mode_q == STANDBY_1 && mode_d == RX_SETTLE) |-> wantRx;
  endproperty
  a_rxentry: assert property (p_rxentry) else $error("bad receive entry");
  property p_drop;
    @(posedge clk) disable iff (!resetn) rxFifoFull |-> !rxFifoWrite;
  endproperty
  a_drop: assert property (p_drop) else $error("write into full FIFO");
  sequence s_sig8;
    (rfSeen && mode_q == RX_ACTIVE) [*8];
  endsequence
  property p_cd;
    @(posedge clk) disable iff (!resetn) $rose(carrier_q) |-> $past(cdCnt_q) == CNT_W'(CARRIER_CYC - 1);
  endproperty
  a_cd: assert property (p_cd) else $error("carrier too early");
  property p_txentry;
    @(posedge clk) disable iff (!resetn)
      (mode_q == STANDBY_1 && mode_d == TX_SETTLE) |-> txReady && activeHigh;
  endproperty
  a_txentry: assert property (p_txentry) else $error("bad transmit entry");
  // Settle age, kept apart from the settle counter so a broken counter shows
  logic [CNT_W-1:0] settleAge_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) settleAge_q <= '0;
    else if (!isSettle) settleAge_q <= '0;
    else if (settleAge_q != '1) settleAge_q <= settleAge_q + 1'b1;
  end
  property p_settle;
    @(posedge clk) disable iff (!resetn)
      isSettle |-> settleAge_q < CNT_W'(SETTLE_CYC);
  endproperty
  a_settle: assert property (p_settle) else $error("settling too long");
  // empty FIFO with pin high goes standby-II
  property p_after;
    @(posedge clk) disable iff (!resetn)
      (finishTx && activeHigh && !oneShot_q && txFifoEmpty && cfg.powerUp)
      |=> mode_q == STANDBY_2;
  endproperty
  a_after: assert property (p_after) else $error("no standby-II");
  property p_cdrun;
    @(posedge clk) disable iff (!resetn)
      s_sig8 |-> (cdCnt_q >= CNT_W'(7)) || carrier_q;
  endproperty
  a_cdrun: assert property (p_cdrun) else $error("carrier count lags");
  property p_cdlow;
    @(posedge clk) disable iff (!resetn)
      (mode_q != RX_ACTIVE || !rfSeen) |=> !carrier_q;
  endproperty
  a_cdlow: assert property (p_cdlow) else $error("carrier flag stuck");
  property p_stby2;
    @(posedge clk) disable iff (!resetn)
      (mode_q == STANDBY_1 && cfg.powerUp && !cfg.primaryRx && activeHigh && txFifoEmpty)
      |=> mode_q == STANDBY_2;
  endproperty
  a_stby2: assert property (p_stby2) else $error("no standby-II entry");
  property p_load;
    @(posedge clk) disable iff (!resetn)
      (mode_q == STANDBY_2 && activeHigh && !cfg.primaryRx && cfg.powerUp && txLoadDone)
      |=> mode_q == TX_SETTLE;
  endproperty
  a_load: assert property (p_load) else $error("load did not start transmit");
  property p_holdrx;
    @(posedge clk) disable iff (!resetn)
      (mode_q == RX_ACTIVE && autoEngineHold && cfg.powerUp) |=> mode_q == RX_ACTIVE;
  endproperty
  a_holdrx: assert property (p_holdrx) else $error("receive left under hold");
  property p_rxstay;
    @(posedge clk) disable iff (!resetn)
      (mode_q == RX_ACTIVE && activeHigh && cfg.primaryRx && cfg.powerUp)
      |=> mode_q == RX_ACTIVE;
  endproperty
  a_rxstay: assert property (p_rxstay) else $error("receive left early");
  property p_write;
    @(posedge clk) disable iff (!resetn)
      rxFifoWrite |-> (mode_q == RX_ACTIVE) && addrMatch && crcOk && rxPacketValid;
  endproperty
  a_write: assert property (p_write) else $error("bad receive write");
  property p_dropflag;
    @(posedge clk) disable iff (!resetn)
      (goodPacket && rxFifoFull) |-> rxPacketDropped;
  endproperty
  a_dropflag: assert property (p_dropflag) else $error("drop not flagged");
  property p_drain;
    @(posedge clk) disable iff (!resetn)
      (finishTx && activeHigh && !oneShot_q && !txFifoEmpty && cfg.powerUp)
      |=> mode_q == TX_ACTIVE;
  endproperty
  a_drain: assert property (p_drain) else $error("transmit stopped early");
  property p_pop;
    @(posedge clk) disable iff (!resetn)
      txFifoPop |-> mode_q == TX_ACTIVE;
  endproperty
  a_pop: assert property (p_pop) else $error("pop outside transmit");
  property p_oneshot;
    @(posedge clk) disable iff (!resetn)
      (finishTx && (oneShot_q || !activeHigh) && cfg.powerUp) |=> mode_q == STANDBY_1;
  endproperty
  a_oneshot: assert property (p_oneshot) else $error("one-shot not ended");
  property p_setfall;
    @(posedge clk) disable iff (!resetn)
      (isSettle && !activeHigh && cfg.powerUp) |=> mode_q == STANDBY_1;
  endproperty
  a_setfall: assert property (p_setfall) else $error("settle kept with pin low");
  property p_setexit;
    @(posedge clk) disable iff (!resetn)
      (mode_q == TX_SETTLE) |=> mode_q inside {TX_SETTLE, TX_ACTIVE, STANDBY_1, POWER_DOWN};
  endproperty
  a_setexit: assert property (p_setexit) else $error("bad settle exit");
  property p_freq;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> radio_q.freqMhz == BASE_FREQ_MHZ + {5'h00, $past(cfg.channelNumber)};
  endproperty
  a_freq: assert property (p_freq) else $error("wrong frequency");
  property p_power;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> radio_q.powerCode == $past(cfg.txPowerLevel)
               && radio_q.rate2m == $past(cfg.airRate2m);
  endproperty
  a_power: assert property (p_power) else $error("wrong rate or power");
  property p_txon;
    @(posedge clk) disable iff (!resetn)
      radio_q.txOn |-> mode_q == TX_ACTIVE && cfg.powerUp;
  endproperty
  a_txon: assert property (p_txon) else $error("transmitter on outside transmit");
  property p_rxon;
    @(posedge clk) disable iff (!resetn)
      radio_q.rxOn |-> mode_q == RX_ACTIVE;
  endproperty
  a_rxon: assert property (p_rxon) else $error("receiver on outside receive");
  property p_pdoff;
    @(posedge clk) disable iff (!resetn)
      mode_q == POWER_DOWN |-> !radio_q.synthOn;
  endproperty
  a_pdoff: assert property (p_pdoff) else $error("synthesizer on in power down");
endmodule : radio_mode_control

//--- host_pin_model.sv
`timescale 1ns/1ps
module host_pin_model #(
  parameter int WAKE_CYC = 6000,
  parameter int MIN_HIGH = 440,
  parameter int MAX_HIGH = 160000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Bench requests
  input  wire logic powerUp,
  input  wire logic wantHigh,
  // Pin
  output logic      activatePin
);
  int wakeCnt;
  int highCnt;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wakeCnt <= 0;
      highCnt <= 0;
      activatePin <= 1'b0;
    end else begin
      wakeCnt <= !powerUp ? 0 : (wakeCnt < WAKE_CYC ? wakeCnt + 1 : wakeCnt);
      highCnt <= activatePin ? highCnt + 1 : 0;
      if (activatePin) begin
        if ((!wantHigh && highCnt >= MIN_HIGH) || highCnt >= MAX_HIGH) begin
          activatePin <= 1'b0;
        end
      end else if (wantHigh && wakeCnt >= WAKE_CYC) begin
        activatePin <= 1'b1;
      end
    end
  end
endmodule : host_pin_model

//--- testbench.sv
`timescale 1ns/1ps
module testbench;
  import radio_mode_pkg::*;
  localparam int LIM = HOLD_CYC + SETTLE_CYC + 600;
  logic clk, resetn, activatePin, wantHigh;
  config_type cfg;
  logic txFifoEmpty, txLoadDone, packetDone, autoEngineHold;
  logic rxPacketValid, addrMatch, crcOk, rxFifoFull, rfSignalPresent;
  mode_type mode;
  radio_type radio;
  logic rxFifoWrite, rxPacketDropped, txFifoPop, carrierDetectFlag, hostAccessOk;
  int errors, cmp_count, seed;
  logic [3:0] pk;
  logic [6:0] ch;
  radio_mode_control DUT (.clk(clk), .resetn(resetn), .cfg(cfg), .activatePin(activatePin),
    .txFifoEmpty(txFifoEmpty), .txLoadDone(txLoadDone), .packetDone(packetDone),
    .autoEngineHold(autoEngineHold), .rxPacketValid(rxPacketValid), .addrMatch(addrMatch),
    .crcOk(crcOk), .rxFifoFull(rxFifoFull), .rfSignalPresent(rfSignalPresent), .mode(mode),
    .radio(radio), .rxFifoWrite(rxFifoWrite), .rxPacketDropped(rxPacketDropped),
    .txFifoPop(txFifoPop), .carrierDetectFlag(carrierDetectFlag),
    .hostAccessOk(hostAccessOk));
  host_pin_model host_pin (.clk(clk), .resetn(resetn), .powerUp(cfg.powerUp),
    .wantHigh(wantHigh), .activatePin(activatePin));
  function automatic logic [11:0] freq_of(input logic [6:0] c);
    return 12'h0960 + {5'h00, c};
  endfunction : freq_of
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wait_mode(input mode_type m, input int lim);
    int i;
    i = 0;
    @(negedge clk);
    while (mode !== m && i < lim) begin
      @(negedge clk);
      i++;
    end
    chk("mode", 32'(m), 32'(mode));
  endtask : wait_mode
  task automatic pulse_done();
    @(posedge clk);
    packetDone <= 1'b1;
    @(negedge clk);
    chk("txFifoPop", 1, 32'(txFifoPop));
    @(posedge clk);
    packetDone <= 1'b0;
  endtask : pulse_done
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Generous span; real run is near 33k cycles
  initial begin
    #(25 * 100000);
    errors++;
    stop_test();
  end
  initial begin
    {cfg, wantHigh, txLoadDone, packetDone, autoEngineHold, rxPacketValid} = '0;
    {addrMatch, crcOk, rxFifoFull, rfSignalPresent, resetn} = '0;
    txFifoEmpty = 1'b1;
    errors = 0;
    cmp_count = 0;
    seed = $urandom(32'h20b0);
    cyc(3);
    resetn <= 1'b1;
    @(negedge clk);
    chk("mode", 32'(POWER_DOWN), 32'(mode));
    for (int i = 0; i < 4; i++) begin
      ch = (i == 0) ? 7'h00 : (i == 3) ? 7'h7f : 7'($urandom);
      @(posedge clk);
      cfg <= '{powerUp: 1'b1, primaryRx: 1'b0, airRate2m: i[0], txPowerLevel: i[1:0],
        channelNumber: ch};
      cyc(4);
      @(negedge clk);
      chk("freqMhz", 32'(freq_of(ch)), 32'(radio.freqMhz));
      chk("rate2m", 32'(i[0]), 32'(radio.rate2m));
      chk("powerCode", 32'(i[1:0]), 32'(radio.powerCode));
      chk("mode", 32'(STANDBY_1), 32'(mode));
    end
    $display("done settings");
    cyc(6100);
    txFifoEmpty <= 1'b0;
    wantHigh <= 1'b1;
    wait_mode(TX_ACTIVE, LIM);
    wantHigh <= 1'b0;
    cyc(6);
    pulse_done();
    wait_mode(STANDBY_1, 4);
    $display("done single shot");
    wantHigh <= 1'b1;
    wait_mode(TX_ACTIVE, LIM);
    pulse_done();
    wait_mode(TX_ACTIVE, 2);
    txFifoEmpty <= 1'b1;
    pulse_done();
    wait_mode(STANDBY_2, 4);
    chk("hostAccessOk", 1, 32'(hostAccessOk));
    txFifoEmpty <= 1'b0;
    txLoadDone <= 1'b1;
    @(posedge clk);
    txLoadDone <= 1'b0;
    wait_mode(TX_ACTIVE, SETTLE_CYC + 20);
    wantHigh <= 1'b0;
    cyc(6);
    pulse_done();
    wait_mode(STANDBY_1, 4);
    $display("done held transmit");
    cfg.primaryRx <= 1'b1;
    cyc(20);
    wait_mode(STANDBY_1, 0);
    wantHigh <= 1'b1;
    wait_mode(RX_ACTIVE, LIM);
    repeat (200) begin
      @(posedge clk);
      pk = 4'($urandom);
      {rxPacketValid, addrMatch, crcOk, rxFifoFull} <= pk;
      @(negedge clk);
      chk("rxFifoWrite", 32'(&pk[3:1] & ~pk[0]), 32'(rxFifoWrite));
      chk("rxPacketDropped", 32'(&pk[3:1] & pk[0]), 32'(rxPacketDropped));
    end
    {rxPacketValid, addrMatch, crcOk, rxFifoFull} <= '0;
    wait_mode(RX_ACTIVE, 0);
    rfSignalPresent <= 1'b1;
    cyc(CARRIER_CYC - 200);
    chk("carrierDetectFlag", 0, 32'(carrierDetectFlag));
    cyc(400);
    chk("carrierDetectFlag", 1, 32'(carrierDetectFlag));
    rfSignalPresent <= 1'b0;
    autoEngineHold <= 1'b1;
    wantHigh <= 1'b0;
    cyc(20);
    wait_mode(RX_ACTIVE, 0);
    autoEngineHold <= 1'b0;
    wait_mode(STANDBY_1, 10);
    chk("carrierDetectFlag", 0, 32'(carrierDetectFlag));
    $display("done receive");
    cfg.powerUp <= 1'b0;
    wait_mode(POWER_DOWN, 4);
    chk("hostAccessOk", 1, 32'(hostAccessOk));
    $display("done power down");
    stop_test();
  end
endmodule : testbench
